/* rtl/lsau_pkg.sv */
// Purpose: shared constants and types of the load/store address unit
// Assumes: 32-bit data path, sixteen general registers
// Notes:   encodings of operation, addressing mode and width live here
package lsau_pkg;

	localparam int          DATA_W        = 32;
	localparam int          IMM_W         = 12;
	localparam int          REG_IDX_W     = 4;
	localparam logic [31:0] PC_READ_AHEAD = 32'h0000_0004;
	localparam logic [31:0] PC_ALIGN_MASK = 32'hFFFF_FFFD;
	localparam logic [31:0] BRANCH_MASK   = 32'hFFFF_FFFE;
	localparam logic [31:0] PAIR_STRIDE   = 32'h0000_0004;
	localparam logic [3:0]  REG_PC        = 4'hF;

	typedef enum logic [1:0] {
		OP_ADDR_GEN = 2'h0,
		OP_LOAD     = 2'h1,
		OP_STORE    = 2'h2
	} lsau_op_type;

	typedef enum logic [1:0] {
		MODE_OFFSET = 2'h0,
		MODE_PRE    = 2'h1,
		MODE_POST   = 2'h2,
		MODE_REGOFF = 2'h3
	} lsau_mode_type;

	typedef enum logic [1:0] {
		SIZE_BYTE = 2'h0,
		SIZE_HALF = 2'h1,
		SIZE_WORD = 2'h2
	} lsau_size_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ACC1 = 3'b010,
		ST_ACC2 = 3'b100
	} lsau_state_type;

endpackage

/* rtl/lsau_core.sv */
// Purpose: address generation and sequencing of single and pair transfers
// Assumes: decoded instruction fields and register values at issue
// Notes:   one instruction in flight; memory answers with MEM_ACK
//
// Behaviour
// - address result is PC base plus or minus immediate
// - no instruction here touches condition flags
// - unsigned narrow loads zero-fill; stores sized
// - signed narrow loads replicate sign bit
// - offset mode leaves base unchanged
// - pre-index accesses and writes back sum
// - post-index accesses base, then writes sum
// - missing immediate means address is base
// - pair forms move a second register
// - single word load to PC branches, bit zero cleared
// - register offset: base plus shifted offset
// - register offset: byte, half, word only
// - PC base is address plus four with bit 1 cleared
// - failed condition writes and accesses nothing
`timescale 1ns/1ps
`default_nettype none
module lsau_core
	import lsau_pkg::*;
(
	input  wire logic                    CLK,
	input  wire logic                    RESET_N,
	input  wire logic                    ISSUE_VALID,
	output logic                         ISSUE_READY,
	input  wire lsau_pkg::lsau_op_type   OP_KIND,
	input  wire lsau_pkg::lsau_mode_type ADDR_MODE,
	input  wire lsau_pkg::lsau_size_type XFER_SIZE,
	input  wire logic                    SIGN_EXT,
	input  wire logic                    IS_PAIR,
	input  wire logic                    OFFSET_ADD,
	input  wire logic [11:0]             IMM_OFFSET,
	input  wire logic [1:0]              SHIFT_AMT,
	input  wire logic                    COND_PASS,
	input  wire logic [31:0]             INSTR_ADDR,
	input  wire logic [31:0]             BASE_VALUE,
	input  wire logic [31:0]             OFFSET_VALUE,
	input  wire logic [31:0]             DATA_VALUE,
	input  wire logic [31:0]             DATA2_VALUE,
	input  wire logic [3:0]              DEST_INDEX,
	input  wire logic [3:0]              DEST2_INDEX,
	input  wire logic [3:0]              BASE_INDEX,
	output logic                         MEM_REQ,
	output logic                         MEM_WRITE,
	output logic [31:0]                  MEM_ADDR,
	output logic [31:0]                  MEM_WDATA,
	output lsau_pkg::lsau_size_type      MEM_SIZE,
	input  wire logic                    MEM_ACK,
	input  wire logic [31:0]             MEM_RDATA,
	output logic                         RF_WE,
	output logic [3:0]                   RF_WIDX,
	output logic [31:0]                  RF_WDATA,
	output logic                         WB_WE,
	output logic [3:0]                   WB_WIDX,
	output logic [31:0]                  WB_WDATA,
	output logic                         BRANCH_VALID,
	output logic [31:0]                  BRANCH_TARGET,
	output logic                         FLAGS_WE,
	output logic                         DONE
);
	import lsau_pkg::*;

	// Add or subtract an unsigned offset
	function automatic logic [31:0] apply_offset(input logic [31:0] base,
		input logic [31:0] offs, input logic add);
		return add ? base + offs : base - offs;
	endfunction

	// Narrow load data widened to a full word
	function automatic logic [31:0] extend_load(input logic [31:0] d,
		input lsau_size_type sz, input logic sgn);
		logic [31:0] r;
		r = d;
		unique case (sz)
			SIZE_BYTE: r = {{24{sgn & d[7]}}, d[7:0]};
			SIZE_HALF: r = {{16{sgn & d[15]}}, d[15:0]};
			SIZE_WORD: r = d;
			// Unused size code passes the word through untouched
			default:   r = d;
		endcase
		return r;
	endfunction

	lsau_state_type state_ff;
	lsau_op_type    op_ff;
	lsau_mode_type  mode_ff;
	lsau_size_type  size_ff;
	logic           sign_ff;
	logic           pair_ff;
	logic [3:0]     dest_ff;
	logic [3:0]     dest2_ff;
	logic [3:0]     base_idx_ff;
	logic [31:0]    ea_ff;
	logic [31:0]    data2_ff;
	logic           accept;
	logic           last_ack;
	logic [31:0]    pc_base;
	logic [31:0]    pc_rel;
	logic [31:0]    imm_ea;
	logic [31:0]    reg_ea;
	logic [31:0]    eff_addr;
	logic [31:0]    first_addr;

	// Stall new work while the finish pulse shows, so the next
	// instruction reads a base that already holds its writeback
	assign ISSUE_READY = (state_ff == ST_IDLE) && !DONE;
	assign accept      = ISSUE_VALID && ISSUE_READY;
	assign last_ack    = MEM_ACK && ((state_ff == ST_ACC2) ||
		((state_ff == ST_ACC1) && !pair_ff));
	assign FLAGS_WE    = 1'b0;

	// Address arithmetic; a zero immediate leaves the base as is
	assign pc_base  = (INSTR_ADDR + PC_READ_AHEAD) & PC_ALIGN_MASK;
	assign pc_rel   = apply_offset(pc_base, {20'h0_0000, IMM_OFFSET},
		OFFSET_ADD);
	assign imm_ea   = apply_offset(BASE_VALUE, {20'h0_0000, IMM_OFFSET},
		OFFSET_ADD);
	assign reg_ea   = BASE_VALUE + (OFFSET_VALUE << SHIFT_AMT);
	assign eff_addr = (ADDR_MODE == MODE_REGOFF) ? reg_ea : imm_ea;
	assign first_addr = (ADDR_MODE == MODE_POST) ? BASE_VALUE
		: eff_addr;

	// Sequencer: idle, first word, second word of a pair
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_ff <= ST_IDLE;
		end else begin
			unique case (state_ff)
				ST_IDLE: begin
					if (accept && COND_PASS && OP_KIND != OP_ADDR_GEN) begin
						state_ff <= ST_ACC1;
					end
				end
				ST_ACC1: begin
					if (MEM_ACK) begin
						state_ff <= pair_ff ? ST_ACC2 : ST_IDLE;
					end
				end
				ST_ACC2: begin
					if (MEM_ACK) begin
						state_ff <= ST_IDLE;
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// Instruction fields held for the whole transfer
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			op_ff       <= OP_ADDR_GEN;
			mode_ff     <= MODE_OFFSET;
			size_ff     <= SIZE_WORD;
			sign_ff     <= 1'b0;
			pair_ff     <= 1'b0;
			dest_ff     <= 4'h0;
			dest2_ff    <= 4'h0;
			base_idx_ff <= 4'h0;
			ea_ff       <= 32'h0000_0000;
			data2_ff    <= 32'h0000_0000;
		end else if (accept) begin
			op_ff       <= OP_KIND;
			mode_ff     <= ADDR_MODE;
			size_ff     <= IS_PAIR ? SIZE_WORD : XFER_SIZE;
			sign_ff     <= SIGN_EXT && (OP_KIND == OP_LOAD);
			pair_ff     <= IS_PAIR && (ADDR_MODE != MODE_REGOFF);
			dest_ff     <= DEST_INDEX;
			dest2_ff    <= DEST2_INDEX;
			base_idx_ff <= BASE_INDEX;
			ea_ff       <= eff_addr;
			data2_ff    <= DATA2_VALUE;
		end
	end

	// Memory request holds until acknowledged
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			MEM_REQ   <= 1'b0;
			MEM_WRITE <= 1'b0;
			MEM_ADDR  <= 32'h0000_0000;
			MEM_WDATA <= 32'h0000_0000;
			MEM_SIZE  <= SIZE_WORD;
		end else if (accept && COND_PASS && OP_KIND != OP_ADDR_GEN) begin
			MEM_REQ   <= 1'b1;
			MEM_WRITE <= (OP_KIND == OP_STORE);
			MEM_ADDR  <= first_addr;
			MEM_WDATA <= DATA_VALUE;
			MEM_SIZE  <= IS_PAIR ? SIZE_WORD : XFER_SIZE;
		end else if (MEM_ACK && state_ff == ST_ACC1 && pair_ff) begin
			MEM_ADDR  <= MEM_ADDR + PAIR_STRIDE;
			MEM_WDATA <= data2_ff;
		end else if (last_ack) begin
			MEM_REQ   <= 1'b0;
		end
	end

	// Data register write: address result or loaded word
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			RF_WE    <= 1'b0;
			RF_WIDX  <= 4'h0;
			RF_WDATA <= 32'h0000_0000;
		end else if (accept && COND_PASS && OP_KIND == OP_ADDR_GEN) begin
			RF_WE    <= 1'b1;
			RF_WIDX  <= DEST_INDEX;
			RF_WDATA <= pc_rel;
		end else if (MEM_ACK && op_ff == OP_LOAD && state_ff != ST_IDLE) begin
			// A first-access load into PC is not written; only a single word load branches
			RF_WE    <= !(state_ff == ST_ACC1 && dest_ff == REG_PC);
			RF_WIDX  <= (state_ff == ST_ACC2) ? dest2_ff : dest_ff;
			RF_WDATA <= extend_load(MEM_RDATA, size_ff, sign_ff);
		end else begin
			RF_WE    <= 1'b0;
		end
	end

	// Base writeback with the final word, visible to the next issue
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			WB_WE    <= 1'b0;
			WB_WIDX  <= 4'h0;
			WB_WDATA <= 32'h0000_0000;
		end else begin
			WB_WE    <= last_ack && (mode_ff == MODE_PRE ||
				mode_ff == MODE_POST);
			WB_WIDX  <= base_idx_ff;
			WB_WDATA <= ea_ff;
		end
	end

	// Finish pulse and branch on a PC load
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			DONE          <= 1'b0;
			BRANCH_VALID  <= 1'b0;
			BRANCH_TARGET <= 32'h0000_0000;
		end else begin
			DONE <= last_ack || (accept && (!COND_PASS ||
				OP_KIND == OP_ADDR_GEN));
			BRANCH_VALID  <= MEM_ACK && state_ff == ST_ACC1 && !pair_ff &&
				op_ff == OP_LOAD && dest_ff == REG_PC &&
				size_ff == SIZE_WORD;
			BRANCH_TARGET <= MEM_RDATA & BRANCH_MASK;
		end
	end

	AST_ADR_RESULT: assert property (@(posedge CLK) disable iff (!RESET_N)
		accept && COND_PASS && OP_KIND == OP_ADDR_GEN |=>
		RF_WE && DONE && RF_WDATA == $past(pc_rel))
		else $error("address result not written");
	AST_NO_FLAGS: assert property (@(posedge CLK) disable iff (!RESET_N)
		DONE |-> !FLAGS_WE)
		else $error("flags written");
	AST_ZERO_FILL: assert property (@(posedge CLK) disable iff (!RESET_N)
		RF_WE && op_ff == OP_LOAD && !sign_ff && size_ff == SIZE_BYTE
		|-> RF_WDATA[31:8] == 24'h00_0000)
		else $error("byte load not zero filled");
	AST_SIGN_FILL: assert property (@(posedge CLK) disable iff (!RESET_N)
		RF_WE && op_ff == OP_LOAD && sign_ff && size_ff == SIZE_HALF
		|-> RF_WDATA[31:16] == {16{RF_WDATA[15]}})
		else $error("half load not sign filled");
	AST_OFFSET_KEEP: assert property (@(posedge CLK) disable iff (!RESET_N)
		DONE && mode_ff == MODE_OFFSET |-> !WB_WE)
		else $error("offset mode wrote base");
	AST_PRE_INDEX: assert property (@(posedge CLK) disable iff (!RESET_N)
		accept && COND_PASS && OP_KIND != OP_ADDR_GEN &&
		ADDR_MODE == MODE_PRE |=> MEM_REQ && MEM_ADDR == $past(imm_ea))
		else $error("pre index address wrong");
	AST_POST_INDEX: assert property (@(posedge CLK) disable iff (!RESET_N)
		accept && COND_PASS && OP_KIND != OP_ADDR_GEN &&
		ADDR_MODE == MODE_POST |=> MEM_ADDR == $past(BASE_VALUE))
		else $error("post index address wrong");
	AST_PAIR_STEP: assert property (@(posedge CLK) disable iff (!RESET_N)
		state_ff == ST_ACC1 && MEM_ACK && pair_ff |=>
		MEM_REQ && MEM_ADDR == $past(MEM_ADDR) + PAIR_STRIDE)
		else $error("second pair word misplaced");
	AST_BRANCH_ALIGN: assert property (@(posedge CLK) disable iff (!RESET_N)
		BRANCH_VALID |-> !BRANCH_TARGET[0] && DONE && !RF_WE)
		else $error("branch target bit zero set");
	AST_REG_OFFSET: assert property (@(posedge CLK) disable iff (!RESET_N)
		accept && COND_PASS && OP_KIND != OP_ADDR_GEN &&
		ADDR_MODE == MODE_REGOFF |=> MEM_ADDR == $past(reg_ea))
		else $error("register offset address wrong");
	AST_COND_FAIL: assert property (@(posedge CLK) disable iff (!RESET_N)
		accept && !COND_PASS |=> DONE && !RF_WE && !MEM_REQ ##1 !WB_WE)
		else $error("failed condition had effect");
	AST_WB_TIMING: assert property (@(posedge CLK) disable iff (!RESET_N)
		WB_WE |-> DONE && !ISSUE_READY && WB_WDATA == ea_ff)
		else $error("writeback apart from finish");

endmodule
`default_nettype wire

/* bench/lsau_mem_model.sv */
// Purpose: data memory stand-in facing the load/store unit
// Assumes: one request at a time, answer after wait_cycles stalls
// Notes:   read data is the inverted byte address
`timescale 1ns/1ps
`default_nettype none
module lsau_mem_model
	import lsau_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        mem_req,
	input  wire logic        mem_write,
	input  wire logic [31:0] mem_addr,
	input  wire logic [3:0]  wait_cycles,
	output logic             mem_ack,
	output logic [31:0]      mem_rdata
);
	logic [3:0] cnt_ff;

	// Idle data toggles so stale read data never passes for fresh
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff    <= 4'h0;
			mem_ack   <= 1'b0;
			mem_rdata <= 32'h0;
		end else if (mem_req && !mem_ack && cnt_ff == wait_cycles) begin
			cnt_ff    <= 4'h0;
			mem_ack   <= 1'b1;
			mem_rdata <= mem_write ? 32'h0 : ~mem_addr;
		end else begin
			mem_ack   <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack)
				cnt_ff <= cnt_ff + 4'h1;
		end
	end
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// Purpose: self-checking bench of the load/store address unit
// Assumes: memory stand-in answers after a chosen stall
// Notes:   go() packs flags as {shift, no_cond, signed, pair, add}
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import lsau_pkg::*;
	logic          clk = 1'b0, rst_n = 1'b0, valid = 1'b0;
	logic          sgn = 1'b0, pair = 1'b0, add = 1'b1, cond = 1'b1;
	logic          rdy, mreq, mwr, ack, rfwe, wbwe, brv, flwe, done;
	lsau_op_type   op = OP_LOAD;
	lsau_mode_type mode = MODE_OFFSET;
	lsau_size_type size = SIZE_WORD;
	lsau_size_type msize;
	logic [11:0]   imm = 12'h0;
	logic [1:0]    sh = 2'h0;
	logic [3:0]    dst = 4'h1, waits = 4'h0, rfi, wbi;
	logic [31:0]   base = 32'h0, maddr, mwd, mrd, rfd, wbd, brt;
	logic [31:0]   rf_d[2], rf_i[2], ma[2], wd[2], wb_d, wb_i, br_d, msz;
	int            n_rf, n_wb, n_br, n_mem, fails, samples_checked, cycles;

	lsau_core dut_u (.CLK(clk), .RESET_N(rst_n), .ISSUE_VALID(valid),
		.ISSUE_READY(rdy), .OP_KIND(op), .ADDR_MODE(mode), .XFER_SIZE(size),
		.SIGN_EXT(sgn), .IS_PAIR(pair), .OFFSET_ADD(add), .IMM_OFFSET(imm),
		.SHIFT_AMT(sh), .COND_PASS(cond), .INSTR_ADDR(base),
		.BASE_VALUE(base), .OFFSET_VALUE({20'h0, imm}), .DATA_VALUE(~base),
		.DATA2_VALUE(32'h5A5A_F0F0), .DEST_INDEX(dst), .DEST2_INDEX(4'h2),
		.BASE_INDEX(4'h4), .MEM_REQ(mreq), .MEM_WRITE(mwr), .MEM_ADDR(maddr),
		.MEM_WDATA(mwd), .MEM_SIZE(msize), .MEM_ACK(ack), .MEM_RDATA(mrd),
		.RF_WE(rfwe), .RF_WIDX(rfi), .RF_WDATA(rfd), .WB_WE(wbwe),
		.WB_WIDX(wbi), .WB_WDATA(wbd), .BRANCH_VALID(brv),
		.BRANCH_TARGET(brt), .FLAGS_WE(flwe), .DONE(done));

	lsau_mem_model mem_u (.clk(clk), .rst_n(rst_n), .mem_req(mreq),
		.mem_write(mwr), .mem_addr(maddr), .wait_cycles(waits),
		.mem_ack(ack), .mem_rdata(mrd));

	// Clock and hang guard
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			fails++;
			results();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Offer one instruction, then log every pulse until DONE
	task automatic go(input lsau_op_type o, input lsau_mode_type m,
		input lsau_size_type s, input logic [5:0] f, input logic [11:0] i,
		input logic [31:0] b, input logic [3:0] d);
		int k;
		@(posedge clk);
		#1;
		op = o;
		mode = m;
		size = s;
		{sh, cond, sgn, pair, add} = f ^ 6'h08;
		imm = i;
		base = b;
		dst = d;
		n_rf = 0;
		n_wb = 0;
		n_br = 0;
		n_mem = 0;
		valid = 1'b1;
		@(posedge clk);
		#1 valid = 1'b0;
		for (k = 0; k < 40; k++) begin
			check(flwe, 1'b0);
			if (rfwe === 1'b1) begin
				rf_i[n_rf[0]] = {28'h0, rfi};
				rf_d[n_rf[0]] = rfd;
				n_rf++;
			end
			if (wbwe === 1'b1) begin
				wb_d = wbd;
				wb_i = {28'h0, wbi};
				n_wb++;
			end
			if (brv === 1'b1) begin
				br_d = brt;
				n_br++;
			end
			if (mreq === 1'b1 && ack === 1'b1) begin
				ma[n_mem[0]] = maddr;
				wd[n_mem[0]] = mwd;
				msz = {30'h0, msize};
				check(mwr, o == OP_STORE);
				n_mem++;
			end
			if (done === 1'b1)
				break;
			@(posedge clk);
			#1;
		end
		check(done, 1'b1);
		check(rdy, 1'b0);
	endtask

	// Sums stay inside 4095 bytes and come out odd for interworking
	task automatic t_adr();
		for (int k = 0; k < 2; k++) begin
			go(OP_ADDR_GEN, MODE_OFFSET, SIZE_WORD, {5'h0, k[0]}, 12'hFFF,
				32'h0000_1002, 4'h3);
			check(rf_d[0], k ? 32'h2003 : 32'h0005);
			check(n_rf + n_mem, 1);
			check(rf_i[0], 32'h3);
		end
		$display("test adr done");
	endtask

	// Offset, pre, post, then empty immediate; stall grows each pass
	task automatic t_modes();
		lsau_mode_type m;
		logic [31:0]   ea;
		logic [31:0]   a;
		for (int k = 0; k < 4; k++) begin
			m = lsau_mode_type'(k % 3);
			ea = k[0] ? 32'h2024 : 32'h1FDC;
			if (k == 3)
				ea = 32'h2000;
			a = (m == MODE_POST) ? 32'h2000 : ea;
			waits = k[3:0];
			go(OP_LOAD, m, SIZE_WORD, {5'h0, k[0]}, (k == 3) ? 12'h0 : 12'h024,
				32'h0000_2000, 4'h1);
			check(ma[0], a);
			check(rf_d[0], ~a);
			check(n_wb, m != MODE_OFFSET);
			if (m != MODE_OFFSET)
				check(wb_d ^ wb_i, ea ^ 32'h4);
		end
		$display("test modes done");
	endtask

	// Shift 0..3 across byte/half, signed and unsigned
	task automatic t_narrow();
		logic [31:0] a;
		logic [31:0] d;
		logic [31:0] e;
		for (int k = 0; k < 4; k++) begin
			a = 32'h3000 + (32'h21 << k);
			d = ~a;
			e = k[1] ? {{24{d[7]}}, d[7:0]} : {24'h0, d[7:0]};
			if (k[0])
				e = k[1] ? {{16{d[15]}}, d[15:0]} : {16'h0, d[15:0]};
			go(OP_LOAD, MODE_REGOFF, lsau_size_type'(k[0]),
				{k[1:0], 1'b0, k[1], 2'h1}, 12'h021, 32'h3000, 4'h5);
			check(ma[0], a);
			check(rf_d[0], e);
			check(msz, {31'h0, k[0]});
		end
		$display("test narrow done");
	endtask

	task automatic t_pair();
		waits = 4'h1;
		go(OP_LOAD, MODE_PRE, SIZE_WORD, 6'h03, 12'h008, 32'h4000,
			4'h1);
		check(ma[0] ^ ma[1], 32'h0000_0004);
		check(ma[1], 32'h400C);
		check(rf_i[1] + rf_i[0], 32'h3);
		check(rf_d[1], ~32'h400C);
		check(wb_d, 32'h4008);
		go(OP_STORE, MODE_POST, SIZE_WORD, 6'h02, 12'h010, 32'h4100,
			4'h1);
		check(ma[1], 32'h4104);
		check(wd[0], ~32'h4100);
		check(wd[1], 32'h5A5A_F0F0);
		check(wb_d + n_rf, 32'h40F0);
		$display("test pair done");
	endtask

	// Loaded PC value is odd; store byte; failed condition
	task automatic t_misc();
		go(OP_LOAD, MODE_OFFSET, SIZE_WORD, 6'h01, 12'h010, 32'h5000,
			4'hF);
		check(br_d, 32'hFFFF_AFEE);
		check(n_br * 2 + n_rf, 2);
		go(OP_STORE, MODE_OFFSET, SIZE_BYTE, 6'h01, 12'h003, 32'h51A5,
			4'h1);
		check({msz[7:0], wd[0][7:0]}, 32'h005A);
		check(ma[0], 32'h51A8);
		go(OP_LOAD, MODE_PRE, SIZE_WORD, 6'h09, 12'h010, 32'h5200, 4'h1);
		check(n_mem + n_rf + n_wb + n_br, 0);
		$display("test misc done");
	endtask

	// Reset for four cycles, then the scenarios in turn
	initial begin
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		t_adr();
		t_modes();
		t_narrow();
		t_pair();
		t_misc();
		results();
	end
endmodule
`default_nettype wire
